/* File: ufs_pkg.sv */
// ufs_pkg: constants and state types of the user flash serial port.
// assumes a single 10 MHz clock with synchronous active-high reset.
package ufs_pkg;
  localparam int          ADDR_W        = 9;
  localparam int          DATA_W        = 16;
  localparam int          WORDS         = 512;
  localparam int          SECTOR_WORDS  = 256;
  localparam logic [8:0]  ADDR_FIRST    = 9'h000;
  localparam logic [8:0]  ADDR_LAST     = 9'h1FF;
  localparam int          SECTOR_BIT    = 8;
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
  localparam logic [7:0]  ECNT_LAST     = 8'hFF;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          PROG_TIME_NS  = 800;
  localparam int          PROG_CYC      =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OSC_DIV       = 4;

  typedef enum logic [3:0] {
    UFS_IDLE  = 4'b0001,
    UFS_PROG  = 4'b0010,
    UFS_ERASE = 4'b0100,
    UFS_DONE  = 4'b1000
  } ufs_fsm_t;

  typedef struct packed {
    ufs_fsm_t    st;
    logic [8:0]  addr;
    logic [15:0] data;
    logic [7:0]  ecnt;
    logic [7:0]  tmr;
    logic        aclk_p;
    logic        dclk_p;
    logic [1:0]  odiv;
    logic        osc;
    logic        busy;
  } ufs_state_t;
endpackage : ufs_pkg

/* File: ufs_mem.sv */
// ufs_mem: word store with one write port and a registered read port.
// assumes the caller keeps write and read addresses in range.
`timescale 1ns/1ps
`default_nettype none
module ufs_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output var  logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    if (rst_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule : ufs_mem
`default_nettype wire

/* File: ufs_top.sv */
// ufs_top: user flash store with serial address/data shift registers,
// self-timed program and sector erase, and a divided oscillator output.
// assumes all inputs are synchronous to clock_i; serial clocks are sampled.
// Functional notes
// - store holds 512 words, 9-bit address 000h to 1FFh.
// - addresses 000h-0FFh form sector 0, 100h-1FFh form sector 1.
// - each word is 16 bits; narrower widths are left to user logic.
// - erase clears exactly one whole sector per request.
// - erasing one sector leaves the other sector untouched.
// - program or erase runs to completion on its own once requested.
// - busy stays high while program or erase runs, drops when done.
// - single reads and sequential stream reads are both supported.
// - address clock with shift control low increments the address.
// - address register is 9 bits, data register 16, both serial.
// - internal operations are timed from the built-in oscillator.
// - oscillator output is internal oscillator divided by four.
// - oscillator frequency is fixed, not programmable.
// - store is also programmed and read through the test port.
// - inputs may come from general routing or global clock lines.
`timescale 1ns/1ps
`default_nettype none
module ufs_top
  import ufs_pkg::*;
#(
  parameter int ADDR_BITS = ufs_pkg::ADDR_W,
  parameter int DATA_BITS = ufs_pkg::DATA_W
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      addr_serial_clk_i,
  input  wire logic                      addr_serial_in_i,
  input  wire logic                      addr_shift_ctl_i,
  input  wire logic                      data_serial_clk_i,
  input  wire logic                      data_serial_in_i,
  input  wire logic                      data_shift_ctl_i,
  input  wire logic                      program_req_i,
  input  wire logic                      erase_req_i,
  input  wire logic                      osc_enable_in_i,
  input  wire logic                      scan_en_i,
  input  wire logic                      scan_wr_i,
  input  wire logic [ufs_pkg::ADDR_W-1:0] scan_addr_i,
  input  wire logic [ufs_pkg::DATA_W-1:0] scan_wdata_i,
  output var  logic [ufs_pkg::DATA_W-1:0] scan_rdata_o,
  output var  logic                      data_serial_out_o,
  output var  logic                      runtime_prog_busy_o,
  output var  logic                      divided_osc_clock_out_o
);
  import ufs_pkg::*;

  // the store geometry is fixed; other widths would break sector split
  if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W)
  begin : g_chk
    $error("ufs_top: only 9-bit address and 16-bit data supported");
  end

  ufs_state_t           s_q;
  ufs_state_t           s_d;
  logic                 we;
  logic [ADDR_W-1:0]    waddr;
  logic [DATA_W-1:0]    wdata;
  logic [ADDR_W-1:0]    raddr;
  logic [DATA_W-1:0]    rdata;
  logic                 aedge;
  logic                 dedge;

  // read port follows the test port while it owns the store
  assign raddr = scan_en_i ? scan_addr_i : s_q.addr;

  ufs_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .we_i    (we),
    .waddr_i (waddr),
    .wdata_i (wdata),
    .raddr_i (raddr),
    .rdata_o (rdata)
  );

  assign scan_rdata_o = rdata;

  always_comb
  begin
    s_d    = s_q;
    we     = 1'b0;
    waddr  = s_q.addr;
    wdata  = s_q.data;
    // serial clocks are sampled levels; act on their rising edge
    aedge  = addr_serial_clk_i & ~s_q.aclk_p;
    dedge  = data_serial_clk_i & ~s_q.dclk_p;
    s_d.aclk_p = addr_serial_clk_i;
    s_d.dclk_p = data_serial_clk_i;

    // address frozen during erase so the target sector cannot move
    if (aedge && s_q.st != UFS_ERASE)
    begin
      if (addr_shift_ctl_i)
      begin
        s_d.addr = {s_q.addr[ADDR_W-2:0], addr_serial_in_i};
      end
      else
      begin
        s_d.addr = s_q.addr + 9'h001;
      end
    end

    if (dedge)
    begin
      if (data_shift_ctl_i)
      begin
        s_d.data = {s_q.data[DATA_W-2:0], data_serial_in_i};
      end
      else
      begin
        // parallel load of the addressed word starts a read
        s_d.data = rdata;
      end
    end

    // internal oscillator is modelled by clock_i; no frequency control
    if (osc_enable_in_i)
    begin
      s_d.odiv = s_q.odiv + 2'h1;
      if (s_q.odiv == 2'(OSC_DIV / 2 - 1))
      begin
        s_d.odiv = 2'h0;
        s_d.osc  = ~s_q.osc;
      end
    end
    else
    begin
      s_d.odiv = 2'h0;
      s_d.osc  = 1'b0;
    end

    unique case (s_q.st)
      UFS_IDLE:
      begin
        if (erase_req_i)
        begin
          s_d.st   = UFS_ERASE;
          s_d.ecnt = 8'h00;
          s_d.busy = 1'b1;
        end
        else if (program_req_i)
        begin
          we       = 1'b1;
          s_d.st   = UFS_PROG;
          s_d.tmr  = 8'(PROG_CYC - 1);
          s_d.busy = 1'b1;
        end
        else if (scan_en_i && scan_wr_i)
        begin
          we    = 1'b1;
          waddr = scan_addr_i;
          wdata = scan_wdata_i;
        end
      end
      UFS_PROG:
      begin
        if (s_q.tmr == 8'h00)
        begin
          s_d.st   = UFS_DONE;
          s_d.busy = 1'b0;
        end
        else
        begin
          s_d.tmr = s_q.tmr - 8'h01;
        end
      end
      UFS_ERASE:
      begin
        // one word per cycle, only inside the addressed sector
        we    = 1'b1;
        waddr = {s_q.addr[SECTOR_BIT], s_q.ecnt};
        wdata = ERASED_WORD;
        if (s_q.ecnt == ECNT_LAST)
        begin
          s_d.st   = UFS_DONE;
          s_d.busy = 1'b0;
        end
        else
        begin
          s_d.ecnt = s_q.ecnt + 8'h01;
        end
      end
      UFS_DONE:
      begin
        // a held request must not restart the operation
        if (!program_req_i && !erase_req_i)
        begin
          s_d.st = UFS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_q <= '{st: UFS_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign data_serial_out_o       = s_q.data[DATA_W-1];
  assign runtime_prog_busy_o     = s_q.busy;
  assign divided_osc_clock_out_o = s_q.osc;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_prog_time;
    (s_q.st == UFS_IDLE && program_req_i && !erase_req_i)
      |=> runtime_prog_busy_o [*8] ##1 !runtime_prog_busy_o;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("program busy length wrong");

  property p_erase_time;
    (s_q.st == UFS_IDLE && erase_req_i)
      |=> runtime_prog_busy_o ##255 runtime_prog_busy_o
          ##1 !runtime_prog_busy_o;
  endproperty
  a_erase_time: assert property (p_erase_time)
    else $error("erase busy length wrong");

  property p_erase_sector;
    (s_q.st == UFS_ERASE && $past(s_q.st) == UFS_ERASE)
      |-> we && waddr[SECTOR_BIT] == $past(waddr[SECTOR_BIT])
      && wdata == ERASED_WORD;
  endproperty
  a_erase_sector: assert property (p_erase_sector)
    else $error("erase touched the other sector");

  property p_addr_inc;
    (aedge && !addr_shift_ctl_i && s_q.st != UFS_ERASE)
      |=> s_q.addr == $past(s_q.addr) + 9'h001;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address did not increment");

  property p_addr_shift;
    (aedge && addr_shift_ctl_i && s_q.st != UFS_ERASE)
      |=> s_q.addr == {$past(s_q.addr[7:0]), $past(addr_serial_in_i)};
  endproperty
  a_addr_shift: assert property (p_addr_shift)
    else $error("address shift wrong");

  property p_data_shift;
    (dedge && data_shift_ctl_i)
      |=> data_serial_out_o == $past(s_q.data[14]);
  endproperty
  a_data_shift: assert property (p_data_shift)
    else $error("data shift wrong");

  property p_osc_idle;
    !osc_enable_in_i |=> !divided_osc_clock_out_o;
  endproperty
  a_osc_idle: assert property (p_osc_idle)
    else $error("oscillator output moved while disabled");

  property p_osc_div;
    (osc_enable_in_i [*4] ##0 $rose(divided_osc_clock_out_o))
      |-> $past(divided_osc_clock_out_o, 3)
      && !$past(divided_osc_clock_out_o, 2);
  endproperty
  a_osc_div: assert property (p_osc_div)
    else $error("oscillator period not four cycles");

  property p_busy_state;
    runtime_prog_busy_o |-> (s_q.st == UFS_PROG || s_q.st == UFS_ERASE);
  endproperty
  a_busy_state: assert property (p_busy_state)
    else $error("busy outside an operation");

  c_erase: cover property ((s_q.st == UFS_ERASE) ##256 (s_q.st == UFS_DONE));
  c_prog: cover property ($fell(runtime_prog_busy_o) && program_req_i);
  c_stream: cover property ((aedge && !addr_shift_ctl_i) ##[1:8] dedge);
endmodule : ufs_top
`default_nettype wire

/* File: ufs_user_model.sv */
// ufs_user_model: user logic driving the serial port and requests.
// assumes calls from the bench; changes lines after falling edges.
`timescale 1ns/1ps
`default_nettype none
module ufs_user_model (
  input  wire logic clock_i,
  input  wire logic dout_i,
  input  wire logic busy_i,
  output var  logic aclk_o,
  output var  logic ain_o,
  output var  logic actl_o,
  output var  logic dclk_o,
  output var  logic din_o,
  output var  logic dctl_o,
  output var  logic prog_o,
  output var  logic erase_o
);
  initial
  begin
    {aclk_o, ain_o, actl_o, dclk_o, din_o, dctl_o, prog_o, erase_o} = '0;
  end

  // clock low and high one cycle each; idle data shows inverse bit
  task automatic apulse(input logic ctl, input logic b);
    @(negedge clock_i);
    actl_o = ctl;
    ain_o  = b;
    aclk_o = 1'b1;
    @(negedge clock_i);
    aclk_o = 1'b0;
    ain_o  = ~b;
  endtask : apulse

  task automatic dpulse(input logic ctl, input logic b);
    @(negedge clock_i);
    dctl_o = ctl;
    din_o  = b;
    dclk_o = 1'b1;
    @(negedge clock_i);
    dclk_o = 1'b0;
    din_o  = ~b;
  endtask : dpulse

  task automatic set_addr(input logic [8:0] a);
    for (int i = 8; i >= 0; i--) apulse(1'b1, a[i]);
  endtask : set_addr

  // two idle cycles cover the store's read latency
  task automatic read_word(output logic [15:0] w);
    repeat (2) @(negedge clock_i);
    dpulse(1'b0, 1'b0);
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge clock_i);
      w[i] = dout_i;
      if (i > 0) dpulse(1'b1, 1'b0);
    end
  endtask : read_word

  task automatic write_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) dpulse(1'b1, w[i]);
  endtask : write_word

  // request held until busy drops; n is -1 if busy never ends
  task automatic request(input logic er, output int n);
    n = 0;
    @(negedge clock_i);
    erase_o = er;
    prog_o  = ~er;
    for (int k = 0; k < 400; k++)
    begin
      @(negedge clock_i);
      if (busy_i) n++;
      else if (n > 0) break;
      if (k == 399) n = -1;
    end
    erase_o = 1'b0;
    prog_o  = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : request
endmodule : ufs_user_model
`default_nettype wire

/* File: test_user_flash_serial_port.sv */
// test_user_flash_serial_port: self-checking bench of ufs_top.
// assumes ufs_pkg and ufs_user_model; no timing beyond clock_i.
`timescale 1ns/1ps
`default_nettype none
module test_user_flash_serial_port;
  import ufs_pkg::*;
  logic        clock_i;
  logic        rst_i;
  logic        aclk, ain, actl, dclk, din, dctl, prog, erase;
  logic        osc_en, scan_en, scan_wr, dout, busy, osc;
  logic [8:0]  scan_addr;
  logic [15:0] scan_wdata, scan_rdata, w;
  int          failures, n_compared, n, tog;

  ufs_top dut_u (
    .clock_i(clock_i), .rst_i(rst_i),
    .addr_serial_clk_i(aclk), .addr_serial_in_i(ain),
    .addr_shift_ctl_i(actl), .data_serial_clk_i(dclk),
    .data_serial_in_i(din), .data_shift_ctl_i(dctl),
    .program_req_i(prog), .erase_req_i(erase),
    .osc_enable_in_i(osc_en), .scan_en_i(scan_en),
    .scan_wr_i(scan_wr), .scan_addr_i(scan_addr),
    .scan_wdata_i(scan_wdata), .scan_rdata_o(scan_rdata),
    .data_serial_out_o(dout), .runtime_prog_busy_o(busy),
    .divided_osc_clock_out_o(osc));

  ufs_user_model user_u (
    .clock_i(clock_i), .dout_i(dout), .busy_i(busy),
    .aclk_o(aclk), .ain_o(ain), .actl_o(actl), .dclk_o(dclk),
    .din_o(din), .dctl_o(dctl), .prog_o(prog), .erase_o(erase));

  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic results();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic op(input logic er, input int exp);
    user_u.request(er, n);
    if (n < 0)
    begin
      failures++;
      $display("unexpected at %0t: request never finished", $time);
      results();
    end
    else
      check(n[15:0], exp[15:0]);
  endtask : op

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    user_u.set_addr(a);
    user_u.read_word(w);
    check(w, exp);
  endtask : rd

  // sector already erased by the caller
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    user_u.set_addr(a);
    user_u.write_word(d);
    op(1'b0, PROG_CYC);
  endtask : wr

  initial
  begin
    {rst_i, osc_en, scan_en, scan_wr} = 4'hF;
    {scan_addr, scan_wdata} = '0;
    failures = 0;
    n_compared = 0;
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    scan_wr = 1'b0;
    scan_en = 1'b0;
    osc_en = 1'b0;
    check({13'h0, busy, osc, dout}, 16'h0000);
    op(1'b1, SECTOR_WORDS);
    user_u.set_addr(9'h1FF);
    op(1'b1, SECTOR_WORDS);
    wr(9'h0FF, 16'h3C5A);
    wr(9'h100, 16'h1234);
    wr(9'h1FF, 16'hA5C3);
    wr(9'h000, 16'h0F0F);
    rd(9'h0FF, 16'h3C5A);
    user_u.apulse(1'b0, 1'b0);
    user_u.read_word(w);
    check(w, 16'h1234);
    rd(9'h1FF, 16'hA5C3);
    user_u.apulse(1'b0, 1'b0);
    user_u.read_word(w);
    check(w, 16'h0F0F);
    $display("program and stream read test done");
    user_u.set_addr(9'h0FF);
    op(1'b1, SECTOR_WORDS);
    rd(9'h0FF, ERASED_WORD);
    rd(9'h000, ERASED_WORD);
    rd(9'h100, 16'h1234);
    rd(9'h1FF, 16'hA5C3);
    $display("sector erase test done");
    scan_en = 1'b1;
    scan_wr = 1'b1;
    scan_addr = 9'h010;
    scan_wdata = 16'hBEEF;
    @(negedge clock_i);
    scan_wr = 1'b0;
    scan_addr = 9'h100;
    repeat (2) @(negedge clock_i);
    check(scan_rdata, 16'h1234);
    scan_en = 1'b0;
    rd(9'h010, 16'hBEEF);
    $display("test port test done");
    osc_en = 1'b1;
    repeat (4) @(negedge clock_i);
    tog = 0;
    w[0] = osc;
    repeat (40)
    begin
      @(negedge clock_i);
      if (osc !== w[0]) tog++;
      w[0] = osc;
    end
    check(tog[15:0], 16'h0014);
    osc_en = 1'b0;
    repeat (2) @(negedge clock_i);
    tog = 0;
    repeat (8)
    begin
      @(negedge clock_i);
      if (osc !== 1'b0) tog++;
    end
    check(tog[15:0], 16'h0000);
    $display("oscillator test done");
    results();
  end
endmodule : test_user_flash_serial_port
`default_nettype wire
